// ===== rtl/fu_uart.sv
// Serial transmitter and receiver with four-entry FIFOs and a byte register port.
//
// Summary of operation
// - Four-entry transmit and receive FIFOs.
// - Bit rate from a sixteen-bit divisor.
// - Enable bit gates transmit and receive.
// - Stop select gives two or one stop.
// - Word length codes give 5 to 8 bits.
// - Break holds the line low until cleared.
// - Parity enable; read returns head parity error.
// - Forced parity sends a one bit.
// - Read field reports receive FIFO count.
// - Write-only receive threshold, levels 0 to 3.
// - Read field reports transmit FIFO count.
// - Write-only transmit threshold, levels 1 to 4.
// - Data available when level exceeds threshold.
// - Data buffer reads receive, writes transmit.
// - Rate is clock over divisor; a zero divisor gives 65536 clocks per bit.
// - Disabling flushes FIFOs and clears the FIFO error flags; frame error is kept.
`timescale 1ns/100ps
module fu_uart
  import fu_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  output logic [7:0] rdata,
  input wire logic rx_pin,
  output logic tx_pin
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] cfg;
    logic [3:0] rx_thr;
    logic [3:0] tx_thr;
    logic [15:0] divisor;
    logic tx_ovf;
    logic rx_ovf;
    logic rx_unf;
    logic frame_err;
    logic [7:0] rdata;
    logic tx_out;
    logic [1:0] rx_sync;
    fu_ser_t tx_state;
    logic [15:0] tx_cnt;
    logic [2:0] tx_bit;
    logic [7:0] tx_shift;
    logic tx_par;
    fu_ser_t rx_state;
    logic [15:0] rx_cnt;
    logic [2:0] rx_bit;
    logic [7:0] rx_shift;
    logic rx_par;
  } fu_st_t;

  fu_st_t st;
  fu_st_t next_st;
  fu_fifo_if txf ();
  fu_fifo_if rxf ();

  logic enable;
  logic [2:0] last_bit;
  logic [15:0] half_div;
  logic rx_in;
  logic rx_data_available_flag;
  logic tx_room_available_flag;
  logic wr_data;
  logic rd_data;
  logic [7:0] rx_byte;

  // ----------------------------------------------------------------
  // FIFOs
  // ----------------------------------------------------------------
  fu_fifo #(.DEPTH(FIFO_DEPTH)) u_txf (.clk(clk), .rstn(rstn), .f(txf));
  fu_fifo #(.DEPTH(FIFO_DEPTH)) u_rxf (.clk(clk), .rstn(rstn), .f(rxf));

  // Decoded controls shared by both engines.
  always_comb begin
    enable = st.cfg[CFG_ENABLE_BIT];
    last_bit = WORD_BASE_BITS + {1'b0, st.cfg[CFG_WLS_HI:CFG_WLS_LO]};
    half_div = {1'b0, st.divisor[15:1]};
    rx_in = st.rx_sync[1];
    rx_data_available_flag = {1'b0, rxf.level} > st.rx_thr;
    tx_room_available_flag = {1'b0, txf.level} < st.tx_thr;
    wr_data = wr_strobe && (addr == ADDR_DATA_BUFFER);
    rd_data = rd_strobe && (addr == ADDR_DATA_BUFFER);
  end

  // Received byte is masked to the word length before storage.
  always_comb begin
    rx_byte = st.rx_shift >> (3'h7 - last_bit);
  end

  // FIFO strobes; writes to the data buffer fill transmit, reads drain receive.
  always_comb begin
    txf.push = wr_data && enable;
    txf.wdata = {1'b0, wdata};
    txf.flush = !enable;
    txf.pop = ((st.tx_state == SER_IDLE) || ((st.tx_state == SER_STOP)
      && !(st.cfg[CFG_TWO_STOP_BIT] && st.tx_bit == 3'h0))) && enable && !st.cfg[CFG_BREAK_BIT]
      && (txf.level != 3'h0) && (st.tx_cnt == 16'h0000);
    rxf.pop = rd_data;
    rxf.flush = !enable;
    rxf.push = (st.rx_state == SER_STOP) && (st.rx_cnt == 16'h0000) && enable;
    rxf.wdata = {st.cfg[CFG_PARITY_BIT] && !st.cfg[CFG_FORCE_ONE_BIT]
      && st.rx_par, rx_byte};
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    next_st.rx_sync = {st.rx_sync[0], rx_pin};

    // Register writes.
    if (wr_strobe) begin
      unique case (addr)
        ADDR_SERIAL_LINE_CONFIG: begin
          next_st.cfg = wdata;
        end
        ADDR_FIFO_LEVEL_THRESHOLD: begin
          if (wdata[7:4] <= RX_THRESHOLD_MAX) begin
            next_st.rx_thr = wdata[7:4];
          end
          if (wdata[3:0] >= TX_THRESHOLD_MIN && wdata[3:0] <= TX_THRESHOLD_MAX) begin
            next_st.tx_thr = wdata[3:0];
          end
        end
        ADDR_DIVISOR_LOW: begin
          next_st.divisor[7:0] = wdata;
        end
        ADDR_DIVISOR_HIGH: begin
          next_st.divisor[15:8] = wdata;
        end
        ADDR_STATUS: begin
          next_st.frame_err = st.frame_err && !wdata[ST_FRAME_ERR];
        end
        default: begin
        end
      endcase
    end

    // Error flags; a clear by disable wins over a hardware set.
    if (txf.push && txf.level == 3'(FIFO_DEPTH)) begin
      next_st.tx_ovf = 1'b1;
    end
    if (rd_data && rxf.level == 3'h0) begin
      next_st.rx_unf = 1'b1;
    end
    if (rxf.push && rxf.level == 3'(FIFO_DEPTH)) begin
      next_st.rx_ovf = 1'b1;
    end

    // Register reads answer in the following cycle.
    next_st.rdata = 8'h00;
    if (rd_strobe) begin
      unique case (addr)
        ADDR_SERIAL_LINE_CONFIG: begin
          next_st.rdata = st.cfg;
          next_st.rdata[CFG_PARITY_BIT] = rxf.rdata[8] && (rxf.level != 3'h0);
        end
        ADDR_FIFO_LEVEL_THRESHOLD: begin
          next_st.rdata = {1'b0, rxf.level, 1'b0, txf.level};
        end
        ADDR_DATA_BUFFER: begin
          next_st.rdata = rxf.rdata[7:0];
        end
        ADDR_DIVISOR_LOW: begin
          next_st.rdata = st.divisor[7:0];
        end
        ADDR_DIVISOR_HIGH: begin
          next_st.rdata = st.divisor[15:8];
        end
        ADDR_STATUS: begin
          next_st.rdata = {2'b00, tx_room_available_flag, rx_data_available_flag, st.frame_err, st.rx_unf, st.rx_ovf, st.tx_ovf};
        end
        default: begin
          next_st.rdata = 8'h00;
        end
      endcase
    end

    // Transmit engine; each bit lasts divisor clocks.
    if (st.tx_cnt != 16'h0000) begin
      next_st.tx_cnt = st.tx_cnt - 16'h0001;
    end else begin
      unique case (st.tx_state)
        SER_IDLE: begin
          next_st.tx_out = 1'b1;
        end
        SER_START: begin
          next_st.tx_out = st.tx_shift[0];
          next_st.tx_par = st.tx_par ^ st.tx_shift[0];
          next_st.tx_shift = {1'b0, st.tx_shift[7:1]};
          next_st.tx_bit = 3'h0;
          next_st.tx_state = SER_DATA;
          next_st.tx_cnt = st.divisor - 16'h0001;
        end
        SER_DATA: begin
          next_st.tx_cnt = st.divisor - 16'h0001;
          if (st.tx_bit != last_bit) begin
            next_st.tx_out = st.tx_shift[0];
            next_st.tx_par = st.tx_par ^ st.tx_shift[0];
            next_st.tx_shift = {1'b0, st.tx_shift[7:1]};
            next_st.tx_bit = st.tx_bit + 3'h1;
          end else if (st.cfg[CFG_PARITY_BIT]) begin
            next_st.tx_out = st.cfg[CFG_FORCE_ONE_BIT] ? 1'b1 : st.tx_par;
            next_st.tx_state = SER_PARITY;
          end else begin
            next_st.tx_out = 1'b1;
            next_st.tx_bit = 3'h0;
            next_st.tx_state = SER_STOP;
          end
        end
        SER_PARITY: begin
          next_st.tx_out = 1'b1;
          next_st.tx_bit = 3'h0;
          next_st.tx_state = SER_STOP;
          next_st.tx_cnt = st.divisor - 16'h0001;
        end
        SER_STOP: begin
          if (st.cfg[CFG_TWO_STOP_BIT] && st.tx_bit == 3'h0) begin
            next_st.tx_bit = 3'h1;
            next_st.tx_cnt = st.divisor - 16'h0001;
          end else begin
            next_st.tx_state = SER_IDLE;
          end
        end
        default: begin
          next_st.tx_state = SER_IDLE;
        end
      endcase
      // A waiting character starts right after the last stop bit, so no stop bit is stretched.
      if (txf.pop) begin
        next_st.tx_shift = txf.rdata[7:0];
        next_st.tx_par = st.cfg[CFG_ODD_BIT];
        next_st.tx_out = 1'b0;
        next_st.tx_state = SER_START;
        next_st.tx_cnt = st.divisor - 16'h0001;
      end
    end

    // Receive engine; samples mid-bit.
    if (st.rx_cnt != 16'h0000) begin
      next_st.rx_cnt = st.rx_cnt - 16'h0001;
    end else begin
      unique case (st.rx_state)
        SER_IDLE: begin
          if (enable && !rx_in) begin
            next_st.rx_state = SER_START;
            next_st.rx_cnt = half_div;
          end
        end
        SER_START: begin
          next_st.rx_state = rx_in ? SER_IDLE : SER_DATA;
          next_st.rx_cnt = st.divisor - 16'h0001;
          next_st.rx_bit = 3'h0;
          next_st.rx_par = st.cfg[CFG_ODD_BIT];
        end
        SER_DATA: begin
          next_st.rx_shift = {rx_in, st.rx_shift[7:1]};
          next_st.rx_par = st.rx_par ^ rx_in;
          next_st.rx_cnt = st.divisor - 16'h0001;
          next_st.rx_bit = st.rx_bit + 3'h1;
          if (st.rx_bit == last_bit) begin
            next_st.rx_state = st.cfg[CFG_PARITY_BIT] ? SER_PARITY : SER_STOP;
          end
        end
        SER_PARITY: begin
          next_st.rx_par = st.rx_par ^ rx_in; // Left at one when parity is wrong.
          next_st.rx_state = SER_STOP;
          next_st.rx_cnt = st.divisor - 16'h0001;
        end
        SER_STOP: begin
          if (!rx_in) begin
            next_st.frame_err = 1'b1;
          end
          next_st.rx_state = SER_IDLE;
        end
        default: begin
          next_st.rx_state = SER_IDLE;
        end
      endcase
    end

    // Disabling stops both engines and clears the FIFO error flags.
    if (!enable) begin
      next_st.tx_ovf = 1'b0;
      next_st.rx_ovf = 1'b0;
      next_st.rx_unf = 1'b0;
      next_st.tx_state = SER_IDLE;
      next_st.rx_state = SER_IDLE;
      next_st.tx_cnt = 16'h0000;
      next_st.rx_cnt = 16'h0000;
      next_st.tx_out = 1'b1;
    end

    // Break overrides whatever the transmitter drives.
    if (next_st.cfg[CFG_BREAK_BIT]) begin
      next_st.tx_out = 1'b0;
    end else if (st.cfg[CFG_BREAK_BIT] && next_st.tx_state == SER_IDLE) begin
      next_st.tx_out = 1'b1;
    end
  end

  // Registers all state.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
      st.cfg <= CONFIG_RESET;
      st.divisor <= DIVISOR_RESET;
      st.rx_thr <= RX_THRESHOLD_RESET;
      st.tx_thr <= TX_THRESHOLD_RESET;
      st.tx_out <= 1'b1;
      st.rx_sync <= 2'b11;
    end else begin
      st <= next_st;
    end
  end

  assign rdata = st.rdata;
  assign tx_pin = st.tx_out;

endmodule

// ===== inc/fu_pkg.sv
// Package of constants and types for the FIFO serial port.
package fu_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_SERIAL_LINE_CONFIG = 8'hbc;
  localparam logic [7:0] ADDR_FIFO_LEVEL_THRESHOLD = 8'hbd;
  localparam logic [7:0] ADDR_DATA_BUFFER = 8'hbe;
  localparam logic [7:0] ADDR_DIVISOR_LOW = 8'hc0;
  localparam logic [7:0] ADDR_DIVISOR_HIGH = 8'hc1;
  localparam logic [7:0] ADDR_STATUS = 8'hc2;

  // ----------------------------------------------------------------
  // Field positions of the configuration register
  // ----------------------------------------------------------------
  localparam int CFG_ENABLE_BIT = 7;
  localparam int CFG_TWO_STOP_BIT = 6;
  localparam int CFG_WLS_HI = 5;
  localparam int CFG_WLS_LO = 4;
  localparam int CFG_BREAK_BIT = 3;
  localparam int CFG_ODD_BIT = 2;
  localparam int CFG_PARITY_BIT = 1;
  localparam int CFG_FORCE_ONE_BIT = 0;

  // Status register bit positions.
  localparam int ST_TX_OVF = 0;
  localparam int ST_RX_OVF = 1;
  localparam int ST_RX_UNF = 2;
  localparam int ST_FRAME_ERR = 3;
  localparam int ST_RDA = 4;
  localparam int ST_TRA = 5;

  // ----------------------------------------------------------------
  // Reset values and sizes
  // ----------------------------------------------------------------
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [15:0] DIVISOR_RESET = 16'h0001;
  localparam logic [3:0] RX_THRESHOLD_RESET = 4'h0;
  localparam logic [3:0] TX_THRESHOLD_RESET = 4'h1;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_PTR_W = 2;
  localparam logic [3:0] RX_THRESHOLD_MAX = 4'h3;
  localparam logic [3:0] TX_THRESHOLD_MIN = 4'h1;
  localparam logic [3:0] TX_THRESHOLD_MAX = 4'h4;
  localparam logic [2:0] WORD_BASE_BITS = 3'h4;

  // Serial engine states.
  typedef enum logic [2:0] {
    SER_IDLE = 3'b000,
    SER_START = 3'b001,
    SER_DATA = 3'b010,
    SER_PARITY = 3'b011,
    SER_STOP = 3'b100
  } fu_ser_t;

endpackage

// ===== inc/fu_fifo_if.sv
// Interface carrying one FIFO's push, pop and status between modules.
`timescale 1ns/100ps
interface fu_fifo_if;
  logic push;
  logic [8:0] wdata;
  logic pop;
  logic flush;
  logic [8:0] rdata;
  logic [2:0] level;
  modport owner (input push, input wdata, input pop, input flush, output rdata, output level);
  modport user (output push, output wdata, output pop, output flush, input rdata, input level);
endinterface

// ===== rtl/fu_fifo.sv
// Small FIFO of nine-bit entries with registered head output.
`timescale 1ns/100ps
module fu_fifo
  import fu_pkg::*;
#(
  parameter int DEPTH = fu_pkg::FIFO_DEPTH
) (
  input wire logic clk,
  input wire logic rstn,
  fu_fifo_if.owner f
);

  typedef struct packed {
    logic [DEPTH-1:0][8:0] mem;
    logic [FIFO_PTR_W-1:0] rd;
    logic [FIFO_PTR_W-1:0] wr;
    logic [2:0] count;
    logic [8:0] head;
  } fu_fifo_st_t;

  fu_fifo_st_t st;
  fu_fifo_st_t next_st;
  logic do_push;
  logic do_pop;

  // Pushes into a full store and pops from an empty one are dropped.
  always_comb begin
    next_st = st;
    do_push = f.push && (st.count != 3'(DEPTH));
    do_pop = f.pop && (st.count != 3'h0);
    if (f.flush) begin
      next_st.rd = '0;
      next_st.wr = '0;
      next_st.count = '0;
    end else begin
      if (do_push) begin
        next_st.mem[st.wr] = f.wdata;
        next_st.wr = st.wr + 1'b1;
      end
      if (do_pop) begin
        next_st.rd = st.rd + 1'b1;
      end
      next_st.count = st.count + 3'(do_push) - 3'(do_pop);
    end
    next_st.head = next_st.mem[next_st.rd];
  end

  // Registers the whole FIFO state.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign f.rdata = st.head;
  assign f.level = st.count;

endmodule

// ===== sim/fu_uart_asserts.sv
// Concurrent checks on the serial port's register and line pins.
`timescale 1ns/100ps
module fu_uart_asserts
  import fu_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr_strobe,
  input wire logic rd_strobe,
  input wire logic [7:0] rdata,
  input wire logic rx_pin,
  input wire logic tx_pin
);
  logic [7:0] cfg;
  logic [15:0] div;
  logic ever;
  logic [19:0] lo;
  logic brk;
  logic en;
  logic mapped;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // Shadow the software settings and count how long the line stays low.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg <= CONFIG_RESET;
      div <= DIVISOR_RESET;
      ever <= 1'b0;
      lo <= 20'h0;
    end else begin
      if (wr_strobe && addr == ADDR_SERIAL_LINE_CONFIG) cfg <= wdata;
      if (wr_strobe && addr == ADDR_DIVISOR_LOW) div[7:0] <= wdata;
      if (wr_strobe && addr == ADDR_DIVISOR_HIGH) div[15:8] <= wdata;
      if (en) ever <= 1'b1;
      lo <= tx_pin ? 20'h0 : lo + 20'h1;
    end
  end
  // Decode the shadowed fields and the mapped addresses.
  assign brk = cfg[CFG_BREAK_BIT];
  assign en = cfg[CFG_ENABLE_BIT];
  assign mapped = addr inside {ADDR_SERIAL_LINE_CONFIG, ADDR_FIFO_LEVEL_THRESHOLD, ADDR_DATA_BUFFER,
    ADDR_DIVISOR_LOW, ADDR_DIVISOR_HIGH, ADDR_STATUS};
  a_rdata_idle: assert property (!rd_strobe |=> rdata == 8'h00)
    else $error("read data not zero outside a read");
  a_unmapped_zero: assert property (rd_strobe && !mapped |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  a_cfg_readback: assert property (rd_strobe && addr == ADDR_SERIAL_LINE_CONFIG |=>
    rdata[7:2] == cfg[7:2] && rdata[0] == cfg[0]) else $error("config readback wrong");
  a_div_readback: assert property (rd_strobe && (addr == ADDR_DIVISOR_LOW || addr == ADDR_DIVISOR_HIGH) |=>
    rdata == ($past(addr) == ADDR_DIVISOR_LOW ? div[7:0] : div[15:8])) else $error("divisor readback wrong");
  a_level_range: assert property (rd_strobe && addr == ADDR_FIFO_LEVEL_THRESHOLD |=>
    rdata[6:4] <= 3'h4 && rdata[2:0] <= 3'h4 && !rdata[7] && !rdata[3]) else $error("fill level out of range");
  a_flush_levels: assert property (rd_strobe && addr == ADDR_FIFO_LEVEL_THRESHOLD && !en && !$past(en) |=>
    rdata == 8'h00) else $error("levels not flushed while disabled");
  a_flush_flags: assert property (rd_strobe && addr == ADDR_STATUS && !en && !$past(en) |=>
    rdata[2:0] == 3'h0) else $error("error flags not cleared while disabled");
  a_status_pad: assert property (rd_strobe && addr == ADDR_STATUS |=> rdata[7:6] == 2'h0)
    else $error("status padding not zero");
  a_break_low: assert property (brk && $past(brk) |-> !tx_pin)
    else $error("line not held low in break");
  a_idle_high: assert property (!ever && !brk && !$past(brk) |-> tx_pin)
    else $error("line active before enable");
  a_start_width: assert property ($rose(tx_pin) && $past(en) |-> lo >= {4'h0, div})
    else $error("low bit shorter than divisor");
  c_data_read: cover property (rd_strobe && addr == ADDR_DATA_BUFFER);
  c_line_rise: cover property ($rose(tx_pin));
  c_break_on: cover property (brk ##1 !tx_pin);
  c_rx_start: cover property ($fell(rx_pin));
endmodule
bind fu_uart fu_uart_asserts i_chk (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
  .rd_strobe(rd_strobe), .rdata(rdata), .rx_pin(rx_pin), .tx_pin(tx_pin));

// ===== sim/fu_remote.sv
// Behavioural far-end serial device that captures and sends characters.
`timescale 1ns/100ps
module fu_remote (
  input wire logic clk,
  input wire logic tx_line,
  input wire logic [7:0] fmt,
  input wire logic [15:0] div,
  output logic rx_line
);
  logic [7:0] got_q[$];
  logic [1:0] tail_q[$];
  int start_q[$];
  int cyc = 0;
  initial rx_line = 1'b1;
  // Cycle count used to time the start edges.
  always @(posedge clk) cyc <= cyc + 1;
  // Sample each frame in the middle of its bits and keep data, parity and stop.
  always begin : rx_frame
    logic [7:0] b;
    logic p;
    logic s;
    int t;
    @(negedge tx_line);
    #1 t = cyc;
    b = 8'h00;
    p = 1'b0;
    repeat (div / 2) @(posedge clk);
    for (int i = 0; i < 5 + fmt[5:4]; i++) begin
      repeat (div) @(posedge clk);
      b[i] = tx_line;
    end
    if (fmt[1]) begin
      repeat (div) @(posedge clk);
      p = tx_line;
    end
    repeat (div) @(posedge clk);
    s = tx_line;
    if (fmt[6]) begin
      repeat (div) @(posedge clk);
      s = s & tx_line;
    end
    got_q.push_back(b);
    tail_q.push_back({p, s});
    start_q.push_back(t);
  end
  // Forget everything captured so far.
  function automatic void clr();
    got_q.delete();
    tail_q.delete();
    start_q.delete();
  endfunction
  // Send one character, optionally with a wrong parity bit or a low stop bit.
  task automatic send(input logic [7:0] d, input logic bad_par, input logic bad_stop);
    logic [7:0] m;
    m = 8'hff >> (3 - fmt[5:4]);
    @(posedge clk);
    rx_line <= 1'b0;
    repeat (div) @(posedge clk);
    for (int i = 0; i < 5 + fmt[5:4]; i++) begin
      rx_line <= d[i];
      repeat (div) @(posedge clk);
    end
    if (fmt[1]) begin
      rx_line <= (fmt[0] | (^(d & m) ^ fmt[2])) ^ bad_par;
      repeat (div) @(posedge clk);
    end
    rx_line <= ~bad_stop;
    repeat (div * (1 + fmt[6])) @(posedge clk);
    rx_line <= 1'b1;
  endtask
endmodule

// ===== sim/fu_uart_tb.sv
// Self-checking testbench of the FIFO serial port.
`timescale 1ns/100ps
`define CHK(n, e, v) begin \
  check_count++; \
  if ((v) !== (e)) begin \
    err_count++; \
    $display("BAD %s exp %h got %h", n, e, v); \
  end \
end
module fu_uart_tb;
  import fu_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr_strobe = 1'b0;
  logic rd_strobe = 1'b0;
  logic [7:0] rdata;
  logic rx_pin;
  logic tx_pin;
  logic [7:0] fmt = 8'h00;
  int err_count = 0;
  int check_count = 0;
  logic [7:0] cfgs [8] = '{8'hb0, 8'h80, 8'h90, 8'ha0, 8'hf0, 8'hb2, 8'hb6, 8'hb3};
  fu_uart i_dut (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr_strobe(wr_strobe),
    .rd_strobe(rd_strobe), .rdata(rdata), .rx_pin(rx_pin), .tx_pin(tx_pin));
  fu_remote i_rem (.clk(clk), .tx_line(tx_pin), .fmt(fmt), .div(16'h0004), .rx_line(rx_pin));
  // Clock of 8 ns.
  always #4 clk = ~clk;
  // Bus write and read cycles.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_strobe <= 1'b1;
    @(posedge clk);
    wr_strobe <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_strobe <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    `CHK($sformatf("reg %h", a), e, d)
  endtask
  task automatic wait_got(input int n);
    for (int i = 0; i < 3000 && i_rem.got_q.size() < n; i++) @(posedge clk);
    `CHK("frames", n, i_rem.got_q.size())
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // Watchdog against a hung run.
  initial begin
    repeat (30000) @(posedge clk);
    err_count++;
    end_sim();
  end
  // Main sequence of tests.
  initial begin
    logic [7:0] c;
    logic [7:0] m;
    logic [7:0] d;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    rchk(ADDR_SERIAL_LINE_CONFIG, 8'h00);
    rchk(ADDR_FIFO_LEVEL_THRESHOLD, 8'h00);
    rchk(ADDR_DIVISOR_LOW, 8'h01);
    rchk(8'hc3, 8'h00);
    wr(ADDR_DATA_BUFFER, 8'h55);
    rchk(ADDR_FIFO_LEVEL_THRESHOLD, 8'h00);
    wr(ADDR_DIVISOR_HIGH, 8'h12);
    rchk(ADDR_DIVISOR_HIGH, 8'h12);
    wr(ADDR_DIVISOR_HIGH, 8'h00);
    wr(ADDR_DIVISOR_LOW, 8'h04);
    $display("test reset done");
    foreach (cfgs[k]) begin
      c = cfgs[k];
      m = 8'hff >> (3 - c[5:4]);
      d = 8'h96 + 8'(k);
      fmt <= c;
      i_rem.clr();
      wr(ADDR_SERIAL_LINE_CONFIG, c);
      wr(ADDR_DATA_BUFFER, d);
      wr(ADDR_DATA_BUFFER, ~d);
      wait_got(2);
      `CHK("tx data", d & m, i_rem.got_q[0])
      `CHK("tx tail", {c[1] & (c[0] | (^(d & m) ^ c[2])), 1'b1}, i_rem.tail_q[0])
      `CHK("frame len", (7 + c[5:4] + c[1] + c[6]) * 4, i_rem.start_q[1] - i_rem.start_q[0])
      i_rem.send(d, 1'b0, 1'b0);
      repeat (8) @(posedge clk);
      rchk(ADDR_FIFO_LEVEL_THRESHOLD, 8'h10);
      rchk(ADDR_SERIAL_LINE_CONFIG, c & 8'hfd);
      rd(ADDR_DATA_BUFFER, d);
      `CHK("rx data", (8'h96 + 8'(k)) & m, d & m)
    end
    $display("test formats done");
    fmt <= 8'hb0;
    wr(ADDR_SERIAL_LINE_CONFIG, 8'hb0);
    for (int i = 0; i < 6; i++) wr(ADDR_DATA_BUFFER, 8'(i));
    rchk(ADDR_FIFO_LEVEL_THRESHOLD, 8'h04);
    rchk(ADDR_STATUS, 8'h01);
    wr(ADDR_SERIAL_LINE_CONFIG, 8'h30);
    rchk(ADDR_FIFO_LEVEL_THRESHOLD, 8'h00);
    rchk(ADDR_STATUS, 8'h20);
    repeat (400) @(posedge clk);
    $display("test overflow done");
    wr(ADDR_SERIAL_LINE_CONFIG, 8'hb0);
    i_rem.send(8'h3c, 1'b0, 1'b0);
    repeat (8) @(posedge clk);
    rchk(ADDR_STATUS, 8'h30);
    wr(ADDR_FIFO_LEVEL_THRESHOLD, 8'h11);
    rchk(ADDR_STATUS, 8'h20);
    wr(ADDR_FIFO_LEVEL_THRESHOLD, 8'h01);
    rchk(ADDR_STATUS, 8'h30);
    wr(ADDR_FIFO_LEVEL_THRESHOLD, 8'h81);
    rchk(ADDR_STATUS, 8'h30);
    wr(ADDR_FIFO_LEVEL_THRESHOLD, 8'h00);
    rchk(ADDR_STATUS, 8'h30);
    rchk(ADDR_DATA_BUFFER, 8'h3c);
    rd(ADDR_DATA_BUFFER, d);
    rchk(ADDR_STATUS, 8'h24);
    $display("test thresholds done");
    fmt <= 8'hb2;
    wr(ADDR_SERIAL_LINE_CONFIG, 8'h32);
    wr(ADDR_SERIAL_LINE_CONFIG, 8'hb2);
    i_rem.send(8'h5a, 1'b1, 1'b0);
    repeat (8) @(posedge clk);
    rchk(ADDR_SERIAL_LINE_CONFIG, 8'hb2);
    rchk(ADDR_DATA_BUFFER, 8'h5a);
    rchk(ADDR_SERIAL_LINE_CONFIG, 8'hb0);
    i_rem.send(8'ha5, 1'b0, 1'b1);
    repeat (8) @(posedge clk);
    rchk(ADDR_STATUS, 8'h38);
    wr(ADDR_STATUS, 8'h08);
    rchk(ADDR_STATUS, 8'h30);
    for (int i = 0; i < 4; i++) i_rem.send(8'(i), 1'b0, 1'b0);
    repeat (8) @(posedge clk);
    rchk(ADDR_FIFO_LEVEL_THRESHOLD, 8'h40);
    rchk(ADDR_STATUS, 8'h32);
    $display("test errors done");
    wr(ADDR_SERIAL_LINE_CONFIG, 8'hb8);
    repeat (20) @(posedge clk);
    `CHK("break line", 1'b0, tx_pin)
    wr(ADDR_SERIAL_LINE_CONFIG, 8'hb0);
    repeat (3) @(posedge clk);
    `CHK("release line", 1'b1, tx_pin)
    $display("test break done");
    end_sim();
  end
endmodule
